// [hw/pwi_pkg.sv]
package pwi_pkg;

    // Source counts.
    localparam int NUM_MASK = 21;
    localparam int NUM_EDGE = 6;
    localparam int NUM_MATCH = 7;
    localparam int NUM_SERIAL = 7;
    localparam int NUM_WIDE = 3;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WDCLR = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_PEND = 8'h0C;
    localparam logic [7:0] REG_MACRO = 8'h10;
    localparam logic [7:0] REG_CTXSW = 8'h14;
    localparam logic [7:0] REG_PRIO_LO = 8'h18;
    localparam logic [7:0] REG_PRIO_HI = 8'h1C;
    localparam logic [7:0] REG_EDGECFG = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;

    // Control register fields.
    localparam int CTRL_WDT_RUN = 0;
    localparam int CTRL_WDT_SEL = 1;
    localparam int CTRL_WDT_FIRST = 3;
    localparam int CTRL_NMI_RISE = 4;
    localparam int CTRL_WIDE = 5;

    // Status register fields.
    localparam int STAT_NMI_PEND = 0;
    localparam int STAT_WDT_PEND = 1;
    localparam int STAT_REQ_VALID = 2;
    localparam int STAT_IN_SVC = 3;
    localparam int STAT_REQ_SRC = 8;

    // Reset values.
    localparam logic [NUM_MASK-1:0] MASK_RESET = 21'h1FFFFF;
    localparam logic [2*NUM_MASK-1:0] PRIO_RESET = 42'h3FFFFFFFFFF;
    localparam logic [1:0] WDT_SEL_RESET = 2'h3;

    // Source identifiers beyond the maskable ones (0 to 20).
    localparam logic [4:0] SRC_NMI = 5'h15;
    localparam logic [4:0] SRC_WDT = 5'h16;
    localparam logic [4:0] SRC_BRK = 5'h17;
    localparam logic [4:0] SRC_BANK_SWITCH_BREAK_INSTRUCTION = 5'h18;
    localparam logic [4:0] SRC_OPERR = 5'h19;

    // Vector table entries.
    localparam logic [15:0] VEC_BRK = 16'h003E;
    localparam logic [15:0] VEC_OPERR = 16'h003C;
    localparam logic [15:0] VEC_NMI = 16'h0002;
    localparam logic [15:0] VEC_WDT = 16'h0004;
    localparam logic [15:0] VEC_MASK_BASE = 16'h0006;

    // Operand check value.
    localparam logic [7:0] GUARD_OK = 8'hFF;

    typedef enum logic [1:0] {PWI_VECTORED, PWI_CONTEXT, PWI_MACRO} pwi_mode_t;

    typedef struct packed {
        logic [4:0] src;
        pwi_mode_t mode;
        logic [1:0] level;
        logic [15:0] vector;
    } pwi_req_t;

endpackage

// [hw/pwi_edge.sv]
`timescale 1ns/1ps
module pwi_edge (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Pin and edge selection.
    input wire logic pinLevel,
    input wire logic riseEn,
    input wire logic fallEn,
    // One-cycle pulse on a selected edge.
    output logic edgeHit
);
    logic prev_ff;
    logic armed_ff;

    // The first sample after reset only primes the history, so a pin that sits high is no edge.
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_ff <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= pinLevel;
            armed_ff <= 1'b1;
        end
    end

    assign edgeHit = armed_ff & ((riseEn & pinLevel & ~prev_ff) | (fallEn & ~pinLevel & prev_ff));

endmodule // pwi_edge

// [hw/pwi_intc.sv]
// Behaviour
// - Watchdog overflow before software clears it raises a nonmaskable request.
// - Once watchdog is enabled, software writes cannot stop it until reset.
// - A control bit picks watchdog or pin nonmaskable request first.
// - Vectored mode branches to handler; CPU pushes and pops PC and status word.
// - Context mode selects a register bank and saves PC and status there.
// - Macro mode starts a firmware transfer leaving PC and status word untouched.
// - Exactly 23 request sources exist beside software requests and operand error.
// - Both break instructions raise a software request outside the default order.
// - Each maskable source gets one of four levels for nesting and arbitration.
// - A macro request during a running macro service waits until it completes.
// - Equal levels resolve by fixed order, lower number wins, starting at 0.
// - Guarded writes raise operand error unless immediate XOR companion equals FFH.
// - Watchdog overflow is nonmaskable; no mask bit blocks it.
// - Pin nonmaskable request raises on the selected edge, never masked.
// - Edge inputs 0 to 3 take default orders 0 to 3, macro capable.
// - Compare matches take default orders 4 to 10, macro capable.
// - Timers 1 to 3 matches come from 8-bit or 16-bit compare per mode.
// - Edge 5, conversion done and seven serial requests take orders 12 to 20.
// - Vectored branch uses the source's table entry inside the lowest 64K.
`timescale 1ns/1ps
module pwi_intc #(
    parameter int WdtTopLog2 = 21
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request sources.
    input wire logic [pwi_pkg::NUM_EDGE-1:0] edgePin,
    input wire logic nmiPin,
    input wire logic [pwi_pkg::NUM_MATCH-1:0] matchNarrow,
    input wire logic [pwi_pkg::NUM_MATCH-1:0] matchWide,
    input wire logic convDone,
    input wire logic [pwi_pkg::NUM_SERIAL-1:0] serialReq,
    // Instruction events from the CPU.
    input wire logic breakInstr,
    input wire logic bankBreakInstr,
    input wire logic guardedWrite,
    input wire logic [7:0] guardImm,
    input wire logic [7:0] guardComp,
    // Request handshake with the CPU.
    output logic reqValid,
    output pwi_pkg::pwi_req_t reqInfo,
    input wire logic reqAck,
    input wire logic cpuReturn,
    input wire logic macroBusy,
    // Watchdog overflow pulse.
    output logic watchdogOverflowReq
);
    import pwi_pkg::*;

    typedef enum {ST_IDLE, ST_OFFER} pwi_state_t;

    pwi_state_t state_ff;
    logic wdtRun_ff, wdtFirst_ff, nmiRise_ff, nmiPend_ff, wdtPend_ff, wdtOvf_ff, pslverr_ff;
    logic [1:0] wdtSel_ff;
    logic [NUM_WIDE-1:0] wide_ff;
    logic [2:0] swPend_ff;
    logic [4:0] inSvc_ff;
    logic [NUM_MASK-1:0] mask_ff, pend_ff, macroEn_ff, ctxEn_ff;
    logic [2*NUM_MASK-1:0] prio_ff;
    logic [2*NUM_EDGE-1:0] edgeCfg_ff;
    logic [WdtTopLog2-1:0] wdtCnt_ff;
    logic [31:0] prdata_ff;
    pwi_req_t reqInfo_ff;

    // Bus decode.
    wire setupPh = psel & ~penable;
    wire wrEn = psel & penable & pwrite;
    wire wrCtrl = wrEn & (paddr == REG_CTRL);
    wire wrClr = wrEn & (paddr == REG_WDCLR);
    wire wrMask = wrEn & (paddr == REG_MASK);
    wire wrPend = wrEn & (paddr == REG_PEND);
    wire wrMacro = wrEn & (paddr == REG_MACRO);
    wire wrCtx = wrEn & (paddr == REG_CTXSW);
    wire wrPrioLo = wrEn & (paddr == REG_PRIO_LO);
    wire wrPrioHi = wrEn & (paddr == REG_PRIO_HI);
    wire wrEdge = wrEn & (paddr == REG_EDGECFG);
    wire addrHit = (paddr[1:0] == 2'h0) & (paddr <= REG_STATUS);
    wire [31:0] ctrlRd = {24'h0, wide_ff, nmiRise_ff, wdtFirst_ff, wdtSel_ff, wdtRun_ff};
    wire [31:0] statRd = {19'h0, reqInfo_ff.src, inSvc_ff, reqValid, wdtPend_ff, nmiPend_ff};
    wire [31:0] rdMux =
        (paddr == REG_CTRL) ? ctrlRd :
        (paddr == REG_MASK) ? {11'h0, mask_ff} :
        (paddr == REG_PEND) ? {11'h0, pend_ff} :
        (paddr == REG_MACRO) ? {11'h0, macroEn_ff} :
        (paddr == REG_CTXSW) ? {11'h0, ctxEn_ff} :
        (paddr == REG_PRIO_LO) ? prio_ff[31:0] :
        (paddr == REG_PRIO_HI) ? {22'h0, prio_ff[41:32]} :
        (paddr == REG_EDGECFG) ? {20'h0, edgeCfg_ff} :
        (paddr == REG_STATUS) ? statRd : 32'h0;

    assign pready = psel & penable;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

    // Edge detectors for the six edge inputs and the nonmaskable pin.
    logic [NUM_EDGE-1:0] edgeHit;
    logic nmiHit;
    for (genvar g = 0; g < NUM_EDGE; g++)
    begin : g_edge
        pwi_edge u_edge (
            .ref_clk(ref_clk),
            .rstn(rstn),
            .pinLevel(edgePin[g]),
            .riseEn(edgeCfg_ff[2*g]),
            .fallEn(edgeCfg_ff[2*g+1]),
            .edgeHit(edgeHit[g])
        );
    end
    pwi_edge u_nmi_edge (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pinLevel(nmiPin),
        .riseEn(nmiRise_ff),
        .fallEn(~nmiRise_ff),
        .edgeHit(nmiHit)
    );

    // Timers 1 to 3 take their match from the wide pair when in 16-bit mode.
    wire [NUM_MATCH-1:0] wideVec = {wide_ff[2], wide_ff[1], wide_ff[1], wide_ff[0], wide_ff[0], 2'h0};
    wire [NUM_MATCH-1:0] matchSrc = (matchWide & wideVec) | (matchNarrow & ~wideVec);
    // Default order: edges 0-3, matches, edge 4, edge 5, conversion, serial.
    wire [NUM_MASK-1:0] maskSet =
        {serialReq, convDone, edgeHit[5], edgeHit[4], matchSrc, edgeHit[3:0]};

    // Watchdog interval is 2^(top - 2*(3-sel)) cycles.
    wire [2:0] wdtShift = {~wdtSel_ff, 1'b0};
    wire [WdtTopLog2-1:0] wdtLimit = {WdtTopLog2{1'b1}} >> wdtShift;
    wire wdtHit = wdtRun_ff & (wdtCnt_ff == wdtLimit);

    // Operand check for guarded writes.
    wire operrSet = guardedWrite & ((guardImm ^ guardComp) != GUARD_OK);

    // Current nesting level: lowest set in-service bit, 4 when none.
    wire [2:0] curLvl = inSvc_ff[0] ? 3'h0 : inSvc_ff[1] ? 3'h1 :
                        inSvc_ff[2] ? 3'h2 : inSvc_ff[3] ? 3'h3 : 3'h4;

    // Maskable arbitration: best level first, then lowest index.
    logic mFound;
    logic [1:0] mLvl;
    logic [4:0] mIdx;
    always_comb
    begin
        mFound = 1'b0;
        mLvl = 2'h3;
        mIdx = 5'h0;
        for (int i = 0; i < NUM_MASK; i++)
        begin
            if (pend_ff[i] && !mask_ff[i] && !inSvc_ff[4] &&
                (macroEn_ff[i] || ({1'b0, prio_ff[2*i+:2]} < curLvl)) &&
                (!mFound || (prio_ff[2*i+:2] < mLvl)))
            begin
                mFound = 1'b1;
                mLvl = prio_ff[2*i+:2];
                mIdx = 5'(i);
            end
        end
    end

    wire nmiAvail = ~inSvc_ff[4] & (nmiPend_ff | wdtPend_ff);
    wire pickWdt = wdtPend_ff & (wdtFirst_ff | ~nmiPend_ff);
    wire anyPick = ~macroBusy & ((|swPend_ff) | nmiAvail | mFound);
    wire [4:0] pickSrc =
        swPend_ff[0] ? SRC_BRK : swPend_ff[1] ? SRC_BANK_SWITCH_BREAK_INSTRUCTION : swPend_ff[2] ? SRC_OPERR :
        nmiAvail ? (pickWdt ? SRC_WDT : SRC_NMI) : mIdx;
    wire pickMask = (pickSrc < SRC_NMI);
    wire [15:0] maskVec = VEC_MASK_BASE + {10'h0, pickSrc, 1'b0};
    wire [15:0] pickVec =
        pickMask ? maskVec : (pickSrc == SRC_NMI) ? VEC_NMI : (pickSrc == SRC_WDT) ? VEC_WDT :
        (pickSrc == SRC_OPERR) ? VEC_OPERR : VEC_BRK;
    wire pwi_mode_t pickMode =
        (pickMask && macroEn_ff[pickSrc]) ? PWI_MACRO :
        ((pickMask && ctxEn_ff[pickSrc]) || pickSrc == SRC_BANK_SWITCH_BREAK_INSTRUCTION) ? PWI_CONTEXT :
        PWI_VECTORED;
    wire pwi_req_t pickReq = '{src: pickSrc, mode: pickMode, level: pickMask ? mLvl : 2'h0,
                               vector: pickVec};

    // Acceptance and flag clearing; a new event in the same cycle wins.
    wire ackNow = (state_ff == ST_OFFER) & reqAck;
    wire ackMask = ackNow & (reqInfo_ff.src < SRC_NMI);
    wire [NUM_MASK-1:0] ackClr = ackMask ? (21'h1 << reqInfo_ff.src) : 21'h0;
    wire [NUM_MASK-1:0] swClr = wrPend ? pwdata[NUM_MASK-1:0] : 21'h0;
    wire [NUM_MASK-1:0] nxt_pend = (pend_ff & ~ackClr & ~swClr) | maskSet;
    wire [2:0] swSet = {operrSet, bankBreakInstr, breakInstr};
    wire [2:0] swAck = {ackNow & (reqInfo_ff.src == SRC_OPERR), ackNow & (reqInfo_ff.src == SRC_BANK_SWITCH_BREAK_INSTRUCTION),
                        ackNow & (reqInfo_ff.src == SRC_BRK)};
    wire [2:0] nxt_swPend = (swPend_ff & ~swAck) | swSet;
    wire nxt_nmiPend = (nmiPend_ff & ~(ackNow & (reqInfo_ff.src == SRC_NMI))) | nmiHit;
    wire nxt_wdtPend = (wdtPend_ff & ~(ackNow & (reqInfo_ff.src == SRC_WDT))) | wdtHit;

    // Nesting stack: pop on return, push on accepted non-macro hardware requests.
    wire [3:0] lowClr = inSvc_ff[3:0] & (inSvc_ff[3:0] - 4'h1);
    wire [4:0] popped = !cpuReturn ? inSvc_ff : inSvc_ff[4] ? {1'b0, inSvc_ff[3:0]} : {1'b0, lowClr};
    wire [4:0] pushBit =
        (ackNow && reqInfo_ff.mode != PWI_MACRO && (reqInfo_ff.src == SRC_NMI || reqInfo_ff.src == SRC_WDT))
            ? 5'h10 :
        (ackMask && reqInfo_ff.mode != PWI_MACRO) ? (5'h1 << reqInfo_ff.level) : 5'h0;
    wire [4:0] nxt_inSvc = popped | pushBit;

    wire [WdtTopLog2-1:0] nxt_wdtCnt = (!wdtRun_ff || wrClr || wdtHit) ? '0 : wdtCnt_ff + 1'b1;
    wire nxt_wdtRun = wdtRun_ff | (wrCtrl & pwdata[CTRL_WDT_RUN]);

    assign reqValid = (state_ff == ST_OFFER);
    assign reqInfo = reqInfo_ff;
    assign watchdogOverflowReq = wdtOvf_ff;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdtRun_ff <= 1'b0;
            wdtSel_ff <= WDT_SEL_RESET;
            wdtFirst_ff <= 1'b0;
            nmiRise_ff <= 1'b0;
            wide_ff <= '0;
            mask_ff <= MASK_RESET;
            pend_ff <= '0;
            macroEn_ff <= '0;
            ctxEn_ff <= '0;
            prio_ff <= PRIO_RESET;
            edgeCfg_ff <= '0;
            wdtCnt_ff <= '0;
            wdtOvf_ff <= 1'b0;
            nmiPend_ff <= 1'b0;
            wdtPend_ff <= 1'b0;
            swPend_ff <= '0;
            inSvc_ff <= '0;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            wdtRun_ff <= nxt_wdtRun;
            wdtCnt_ff <= nxt_wdtCnt;
            wdtOvf_ff <= wdtHit;
            pend_ff <= nxt_pend;
            swPend_ff <= nxt_swPend;
            nmiPend_ff <= nxt_nmiPend;
            wdtPend_ff <= nxt_wdtPend;
            inSvc_ff <= nxt_inSvc;
            if (wrCtrl)
            begin
                wdtSel_ff <= pwdata[CTRL_WDT_SEL+:2];
                wdtFirst_ff <= pwdata[CTRL_WDT_FIRST];
                nmiRise_ff <= pwdata[CTRL_NMI_RISE];
                wide_ff <= pwdata[CTRL_WIDE+:NUM_WIDE];
            end
            if (wrMask) mask_ff <= pwdata[NUM_MASK-1:0];
            if (wrMacro) macroEn_ff <= pwdata[NUM_MASK-1:0];
            if (wrCtx) ctxEn_ff <= pwdata[NUM_MASK-1:0];
            if (wrPrioLo) prio_ff[31:0] <= pwdata;
            if (wrPrioHi) prio_ff[41:32] <= pwdata[9:0];
            if (wrEdge) edgeCfg_ff <= pwdata[2*NUM_EDGE-1:0];
            if (setupPh)
            begin
                pslverr_ff <= ~addrHit;
                prdata_ff <= pwrite ? 32'h0 : rdMux;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            reqInfo_ff <= '0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    if (anyPick)
                    begin
                        reqInfo_ff <= pickReq;
                        state_ff <= ST_OFFER;
                    end
                end
                ST_OFFER:
                begin
                    if (reqAck) state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    property p_wdt_overflow;
        @(posedge ref_clk) disable iff (!rstn) wdtHit |=> wdtPend_ff && watchdogOverflowReq;
    endproperty
    a_wdt_overflow: assert property (p_wdt_overflow) else $error("watchdog overflow lost");

    property p_wdt_sticky;
        @(posedge ref_clk) disable iff (!rstn) wdtRun_ff |=> wdtRun_ff;
    endproperty
    a_wdt_sticky: assert property (p_wdt_sticky) else $error("watchdog stopped by software");

    property p_nmi_order;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_IDLE && swPend_ff == 3'h0 && nmiPend_ff && wdtPend_ff && !inSvc_ff[4] && !macroBusy)
        |=> reqValid && reqInfo.src == ($past(wdtFirst_ff) ? SRC_WDT : SRC_NMI);
    endproperty
    a_nmi_order: assert property (p_nmi_order) else $error("wrong nonmaskable order");

    property p_mode_sel;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_IDLE && anyPick && pickMask) |=>
        reqInfo.mode == ($past(macroEn_ff[pickSrc]) ? PWI_MACRO :
                         $past(ctxEn_ff[pickSrc]) ? PWI_CONTEXT : PWI_VECTORED);
    endproperty
    a_mode_sel: assert property (p_mode_sel) else $error("wrong handling mode");

    property p_macro_wait;
        @(posedge ref_clk) disable iff (!rstn) (state_ff == ST_IDLE && macroBusy) |=> !reqValid;
    endproperty
    a_macro_wait: assert property (p_macro_wait) else $error("request offered during macro");

    property p_operand;
        @(posedge ref_clk) disable iff (!rstn)
        (guardedWrite && (guardImm ^ guardComp) != 8'hFF) |=> swPend_ff[2];
    endproperty
    a_operand: assert property (p_operand) else $error("operand error missed");

    property p_break;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_IDLE && !macroBusy && (breakInstr || bankBreakInstr))
        |=> ##1 reqValid && (reqInfo.src == SRC_BRK || reqInfo.src == SRC_BANK_SWITCH_BREAK_INSTRUCTION || reqInfo.src == SRC_OPERR);
    endproperty
    a_break: assert property (p_break) else $error("software request not offered");

    property p_wdt_unmasked;
        @(posedge ref_clk) disable iff (!rstn)
        (state_ff == ST_IDLE && wdtPend_ff && !inSvc_ff[4] && !macroBusy) |=> reqValid;
    endproperty
    a_wdt_unmasked: assert property (p_wdt_unmasked) else $error("watchdog request blocked");

    property p_vector;
        @(posedge ref_clk) disable iff (!rstn)
        (reqValid && reqInfo.src < SRC_NMI) |-> reqInfo.vector == 16'h0006 + 16'(2 * reqInfo.src);
    endproperty
    a_vector: assert property (p_vector) else $error("wrong vector entry");

    property p_ack_clear;
        @(posedge ref_clk) disable iff (!rstn)
        (ackMask && !maskSet[reqInfo.src]) |=> !pend_ff[$past(reqInfo.src)];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("pending flag kept after accept");

endmodule // pwi_intc

// [verification/pwi_cpu_model.sv]
`timescale 1ns/1ps
module pwi_cpu_model (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Offer and test controls.
    input wire logic reqValid,
    input wire pwi_pkg::pwi_req_t reqInfo,
    input wire logic stall,
    input wire logic slow,
    // Core answers.
    output logic reqAck,
    output logic cpuReturn,
    output logic macroBusy
);
    import pwi_pkg::*;
    logic [2:0] wait_ff;
    logic [2:0] ret_ff;
    logic [2:0] busy_ff;
    // The core accepts at once or three cycles late, and leaves a handler two cycles on.
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            {reqAck, cpuReturn, macroBusy} <= 3'h0;
            {wait_ff, ret_ff, busy_ff} <= 9'h000;
        end
        else
        begin
            cpuReturn <= (ret_ff == 3'h1);
            ret_ff <= (ret_ff != 3'h0) ? ret_ff - 3'h1 : 3'h0;
            macroBusy <= (busy_ff > 3'h1);
            busy_ff <= (busy_ff != 3'h0) ? busy_ff - 3'h1 : 3'h0;
            wait_ff <= reqValid ? wait_ff + 3'h1 : 3'h0;
            if (reqAck && reqValid)
            begin
                reqAck <= 1'b0;
                if (reqInfo.mode == PWI_MACRO)
                begin
                    macroBusy <= 1'b1;
                    busy_ff <= 3'h6;
                end
                else
                    ret_ff <= 3'h2;
            end
            else if (reqValid && !stall && wait_ff >= (slow ? 3'h3 : 3'h0))
                reqAck <= 1'b1;
        end
    end
endmodule // pwi_cpu_model

// [verification/pwi_intc_test.sv]
`timescale 1ns/1ps
module pwi_intc_test;
    import pwi_pkg::*;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, nmiPin, convDone;
    logic breakInstr, bankBreakInstr, guardedWrite, reqValid, reqAck, cpuReturn;
    logic macroBusy, wdOvf, stall, slow, watchOn, prevValid, rerr;
    logic [7:0] paddr, guardImm, guardComp;
    logic [31:0] pwdata, prdata, rdat;
    logic [5:0] edgePin;
    logic [6:0] matchNarrow, matchWide, serialReq;
    logic [15:0] seed;
    logic [41:0] prio;
    logic [20:0] act;
    logic [22:0] expQ[$];
    pwi_req_t reqInfo;
    int fail_count, cmp_count, cnt;

    pwi_intc #(.WdtTopLog2(7)) dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .edgePin(edgePin), .nmiPin(nmiPin),
        .matchNarrow(matchNarrow), .matchWide(matchWide), .convDone(convDone),
        .serialReq(serialReq), .breakInstr(breakInstr), .bankBreakInstr(bankBreakInstr),
        .guardedWrite(guardedWrite), .guardImm(guardImm), .guardComp(guardComp),
        .reqValid(reqValid), .reqInfo(reqInfo), .reqAck(reqAck), .cpuReturn(cpuReturn),
        .macroBusy(macroBusy), .watchdogOverflowReq(wdOvf));
    pwi_cpu_model cpu (.ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid),
        .reqInfo(reqInfo), .stall(stall), .slow(slow), .reqAck(reqAck),
        .cpuReturn(cpuReturn), .macroBusy(macroBusy));

    function logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function logic [22:0] ex(input logic [4:0] s, input pwi_mode_t m, input logic [15:0] v);
        return {s, m, v};
    endfunction
    function logic [22:0] mv(input logic [4:0] s);
        return ex(s, PWI_VECTORED, VEC_MASK_BASE + {10'h000, s, 1'b0});
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'h0;
        check(n < 20, 1'b1);
    endtask
    task fire(input logic [6:0] mn, mw, input logic cd, input logic [6:0] sr, input logic [2:0] sw);
        @(posedge ref_clk);
        {matchNarrow, matchWide, convDone, serialReq} <= {mn, mw, cd, sr};
        {guardedWrite, bankBreakInstr, breakInstr} <= sw;
        @(posedge ref_clk);
        {matchNarrow, matchWide, convDone, serialReq} <= 22'h000000;
        {guardedWrite, bankBreakInstr, breakInstr} <= 3'h0;
    endtask
    task drain(input string name);
        cnt = 0;
        while (expQ.size() != 0 && cnt < 2000)
        begin
            @(posedge ref_clk);
            seed = lfsr(seed);
            slow <= seed[0];
            cnt++;
        end
        repeat (30) @(posedge ref_clk);
        check(expQ.size(), 0);
        $display("Test %s finished", name);
    endtask
    task summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
    // Each accepted offer is matched against the oldest expected one.
    always @(posedge ref_clk)
    begin
        if (rstn && watchOn && reqValid && !prevValid)
            check(macroBusy, 1'b0);
        if (rstn && watchOn && reqValid && reqAck)
            check({reqInfo.src, reqInfo.mode, reqInfo.vector},
                (expQ.size() != 0) ? expQ.pop_front() : 23'h7FFFFF);
        prevValid <= reqValid;
    end

    initial
    begin
        {rstn, psel, penable, pwrite, nmiPin, convDone, breakInstr, stall, slow} = 9'h000;
        {bankBreakInstr, guardedWrite, watchOn} = 3'h1;
        {paddr, pwdata, edgePin, matchNarrow, matchWide, serialReq, guardImm, guardComp} = '0;
        {fail_count, cmp_count, seed} = {32'h0, 32'h0, 16'h7846};
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        apb(1'b0, REG_MASK, 32'h0);
        check(rdat, 32'h001FFFFF);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rdat, 32'h00000006);
        apb(1'b0, REG_PRIO_LO, 32'h0);
        check(rdat, 32'hFFFFFFFF);
        apb(1'b0, 8'h28, 32'h0);
        check(rdat, 32'h0);
        check({31'h0, rerr}, 32'h1);
        fire(7'h7F, 7'h00, 1'b1, 7'h7F, 3'h0);
        drain("masked");
        apb(1'b1, REG_PEND, 32'h001FFFFF);
        apb(1'b1, REG_MASK, 32'h0);
        repeat (4)
        begin
            seed = lfsr(seed);
            prio[41:32] = seed[9:0];
            seed = lfsr(seed);
            prio[31:16] = seed;
            seed = lfsr(seed);
            prio[15:0] = seed;
            apb(1'b1, REG_PRIO_LO, prio[31:0]);
            apb(1'b1, REG_PRIO_HI, {22'h0, prio[41:32]});
            seed = lfsr(seed);
            act = {seed[14:8], seed[7], 2'h0, seed[6:0], 4'h0};
            for (int l = 0; l < 4; l++)
                for (int s = 4; s < 21; s++)
                    if (act[s] && prio[2*s+:2] == l[1:0])
                        expQ.push_back(mv(5'(s)));
            fire(seed[6:0], 7'h00, seed[7], seed[14:8], 3'h0);
            drain("priority");
        end
        apb(1'b1, REG_PRIO_LO, 32'h0);
        apb(1'b1, REG_PRIO_HI, 32'h0);
        apb(1'b1, REG_EDGECFG, 32'h00000555);
        for (int s = 0; s < 13; s++)
            if (s < 4 || s > 10)
                expQ.push_back(mv(5'(s)));
        edgePin <= 6'h3F;
        drain("edges");
        edgePin <= 6'h00;
        drain("falling");
        apb(1'b1, REG_CTXSW, 32'h00000010);
        apb(1'b1, REG_MACRO, 32'h00006000);
        expQ.push_back(ex(5'h04, PWI_CONTEXT, 16'h000E));
        expQ.push_back(ex(5'h0D, PWI_MACRO, 16'h0020));
        expQ.push_back(ex(5'h0E, PWI_MACRO, 16'h0022));
        fire(7'h01, 7'h00, 1'b1, 7'h00, 3'h0);
        repeat (5) @(posedge ref_clk);
        fire(7'h00, 7'h00, 1'b0, 7'h01, 3'h0);
        drain("modes");
        apb(1'b1, REG_CTRL, 32'h000000E0);
        expQ.push_back(mv(5'h06));
        fire(7'h04, 7'h00, 1'b0, 7'h00, 3'h0);
        fire(7'h00, 7'h04, 1'b0, 7'h00, 3'h0);
        drain("wide");
        apb(1'b1, REG_CTRL, 32'h0);
        {guardImm, guardComp} <= 16'h5AA5;
        fire(7'h00, 7'h00, 1'b0, 7'h00, 3'h4);
        guardComp <= 8'h5A;
        expQ.push_back(ex(SRC_OPERR, PWI_VECTORED, VEC_OPERR));
        expQ.push_back(ex(SRC_BRK, PWI_VECTORED, VEC_BRK));
        expQ.push_back(ex(SRC_BANK_SWITCH_BREAK_INSTRUCTION, PWI_CONTEXT, VEC_BRK));
        fire(7'h00, 7'h00, 1'b0, 7'h00, 3'h4);
        fire(7'h00, 7'h00, 1'b0, 7'h00, 3'h1);
        fire(7'h00, 7'h00, 1'b0, 7'h00, 3'h2);
        drain("software");
        stall <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h0000001F);
        fire(7'h00, 7'h00, 1'b0, 7'h00, 3'h1);
        nmiPin <= 1'b1;
        cnt = 0;
        while (wdOvf !== 1'b1 && cnt < 300)
        begin
            @(posedge ref_clk);
            cnt++;
        end
        check(cnt > 100 && cnt < 140, 1'b1);
        expQ.push_back(ex(SRC_BRK, PWI_VECTORED, VEC_BRK));
        expQ.push_back(ex(SRC_WDT, PWI_VECTORED, VEC_WDT));
        expQ.push_back(ex(SRC_NMI, PWI_VECTORED, VEC_NMI));
        stall <= 1'b0;
        drain("nonmaskable");
        watchOn <= 1'b0;
        apb(1'b1, REG_CTRL, 32'h0);
        cnt = 0;
        while (wdOvf !== 1'b1 && cnt < 300)
        begin
            @(posedge ref_clk);
            cnt++;
        end
        check(cnt < 200, 1'b1);
        summarize();
    end
endmodule // pwi_intc_test
